// >>> verilog/pos_opt_map.svh
`ifndef POS_OPT_MAP_SVH
`define POS_OPT_MAP_SVH
// object indices and sub-entries
`define OBJ_FEED_REVS 16'h60EE
`define OBJ_POS_OPT 16'h60F2
`define SUB_COUNT 8'h00
// preset values
`define COUNT_RESET 8'h03
`define REVS_RESET 32'h00000001
`define OPT_RESET 16'h0001
// option word field positions
`define REL_LSB 0
`define SRO_LSB 4
`define DIR_LSB 6
// feedbacks the array can hold
`define FB_MAX 2'h3
// serial divider steps, one quotient bit per clock
`define DIV_STEPS 6'h20
`endif

// >>> verilog/pos_opt_pkg.sv
package pos_opt_pkg;
    // reference of a relative move
    typedef enum logic [1:0] {
        REL_PREV = 2'b00,
        REL_RAMP = 2'b01,
        REL_ACTUAL = 2'b10
    } rel_ref_t;
    // self-release of the new-setpoint bit
    typedef enum logic [1:0] {
        SRO_NONE = 2'b00,
        SRO_ON_DONE = 2'b01,
        SRO_EARLY = 2'b10
    } release_t;
    // rotary axis direction
    typedef enum logic [1:0] {
        DIR_LINEAR = 2'b00,
        DIR_NEG = 2'b01,
        DIR_POS = 2'b10,
        DIR_SHORT = 2'b11
    } rot_dir_t;
    // serial divider state
    typedef enum logic {
        DIV_IDLE = 1'b0,
        DIV_RUN = 1'b1
    } div_state_t;
    typedef logic signed [31:0] pos_t;
endpackage

// >>> verilog/feed_divider.sv
`timescale 1ns/1ps
`include "pos_opt_map.svh"
module feed_divider (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request
    input wire logic start,
    input wire logic [31:0] dividend,
    input wire logic [31:0] divisor,
    // result
    output logic busy,
    output logic done_q,
    output logic zero_q,
    output logic [31:0] quo_q
);
    import pos_opt_pkg::*;
    div_state_t st_q;
    logic [32:0] rem_q;
    logic [31:0] div_q;
    logic [31:0] num_q;
    logic [5:0] cnt_q;
    logic [32:0] shifted;
    logic [32:0] trial;

    assign busy = (st_q == DIV_RUN);
    assign shifted = {rem_q[31:0], quo_q[31]};
    assign trial = shifted - {1'b0, div_q};

    // restoring division; slow but small, a feed constant changes rarely
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= DIV_IDLE;
            rem_q <= 33'h0;
            div_q <= 32'h0;
            num_q <= 32'h0;
            quo_q <= 32'h0;
            cnt_q <= 6'h0;
            done_q <= 1'b0;
            zero_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (st_q)
                DIV_IDLE: begin
                    if (start && divisor == 32'h0) begin
                        zero_q <= 1'b1; // a zero divisor yields no quotient
                        quo_q <= 32'h0;
                        done_q <= 1'b1;
                    end else if (start) begin
                        zero_q <= 1'b0;
                        div_q <= divisor;
                        num_q <= dividend;
                        quo_q <= dividend;
                        rem_q <= 33'h0;
                        cnt_q <= `DIV_STEPS;
                        st_q <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    if (!trial[32]) begin
                        rem_q <= trial;
                        quo_q <= {quo_q[30:0], 1'b1};
                    end else begin
                        rem_q <= shifted;
                        quo_q <= {quo_q[30:0], 1'b0};
                    end
                    cnt_q <= cnt_q - 6'h1;
                    if (cnt_q == 6'h1) begin
                        done_q <= 1'b1;
                        st_q <= DIV_IDLE;
                    end
                end
                default: st_q <= DIV_IDLE;
            endcase
        end
    end

    // done rises at the 32nd step edge, so it is first seen one edge later
    div_latency_a: assert property (@(posedge clk) disable iff (!rst_n)
        start && !busy && divisor != 32'h0 |-> ##33 done_q)
        else $error("quotient not ready 33 clocks after start");
    div_value_a: assert property (@(posedge clk) disable iff (!rst_n)
        done_q && !zero_q |-> {32'h0, quo_q} * {32'h0, div_q} <= {32'h0, num_q}
        && ({32'h0, quo_q} + 64'h1) * {32'h0, div_q} > {32'h0, num_q})
        else $error("feed constant is not the quotient");
endmodule

// >>> verilog/path_select.sv
`timescale 1ns/1ps
module path_select (
    // mode and positions
    input wire pos_opt_pkg::rot_dir_t mode,
    input wire pos_opt_pkg::pos_t current,
    input wire pos_opt_pkg::pos_t target,
    input wire pos_opt_pkg::pos_t range_min,
    input wire pos_opt_pkg::pos_t range_max,
    // decision
    output logic move_pos,
    output logic via_limit,
    output logic long_ok
);
    import pos_opt_pkg::*;
    logic [31:0] span;
    logic [31:0] diff;

    assign span = range_max - range_min;
    // forward distance folded into one turn of the axis
    assign diff = (target < current) ? target - current + span : target - current;

    always_comb begin
        move_pos = 1'b1;
        via_limit = 1'b0;
        long_ok = 1'b0;
        case (mode)
            DIR_LINEAR: begin
                move_pos = (target >= current);
                long_ok = 1'b1;
            end
            DIR_NEG: begin
                move_pos = 1'b0;
                via_limit = (target > current);
            end
            DIR_POS: begin
                move_pos = 1'b1;
                via_limit = (target < current);
            end
            DIR_SHORT: begin
                move_pos = (diff < (span >> 1));
                via_limit = move_pos ? (target < current) : (target > current);
            end
            default: move_pos = 1'b1;
        endcase
    end
endmodule

// >>> verilog/positioning_option_decoder.sv
`timescale 1ns/1ps
`include "pos_opt_map.svh"
// How it works
// - feed constant per feedback is feed divided by its shaft revolutions
// - revolution array sub-entry zero is read-only feedback count, preset three
// - element one is the always-present sensorless feedback, others follow
// - each revolution element is unsigned 32-bit read/write, preset one
// - 16-bit read/write option word preset 0x0001 steers profile moves
// - reference 00 adds relative move to last target, or zero
// - reference 01 adds relative move to ramp generator output
// - reference 10 adds relative move to actual position; 11 reserved
// - self-release clears new-setpoint bit, then clears setpoint acknowledge
// - release 00 never self-releases; 01 releases when move reaches target
// - release 10 frees the bit as early as possible; 11 reserved
// - direction 00 heads straight for the target, never via a limit, only mode allowing long moves
// - direction 01 moves only negative, passing minimum limit if needed
// - direction 10 moves only positive, passing maximum limit if needed
// - direction 11 takes shortest path, positive when under half turn
module positioning_option_decoder (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // object access
    input wire logic obj_req,
    input wire logic obj_write,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_subindex,
    input wire logic [31:0] obj_wdata,
    output logic obj_ack,
    output logic obj_err,
    output logic [31:0] obj_rdata,
    // feedback set-up
    input wire logic [1:0] fb_present,
    // feed constant
    input wire logic calc_start,
    input wire logic [1:0] calc_fb,
    input wire logic [31:0] feed_in,
    output logic calc_busy,
    output logic calc_done,
    output logic calc_div_zero,
    output logic [31:0] feed_const,
    // profile position control
    input wire logic cw_new_setpoint,
    input wire logic cw_relative,
    input wire logic move_done,
    input wire pos_opt_pkg::pos_t target_in,
    input wire pos_opt_pkg::pos_t ramp_pos,
    input wire pos_opt_pkg::pos_t actual_pos,
    input wire pos_opt_pkg::pos_t range_min,
    input wire pos_opt_pkg::pos_t range_max,
    // profile position results
    output pos_opt_pkg::pos_t abs_target,
    output logic cw_release,
    output logic sw_ack_clear,
    output logic move_positive,
    output logic via_limit,
    output logic long_move_ok
);
    import pos_opt_pkg::*;

    // ------------------------------------------------
    // reset release
    // ------------------------------------------------
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // ------------------------------------------------
    // object decode
    // ------------------------------------------------
    logic [7:0] count_q;
    logic [31:0] revs_q [0:2];
    logic [15:0] opt_q;
    rel_ref_t rel_q;
    release_t sro_q;
    rot_dir_t dir_q;
    logic hit_revs;
    logic hit_opt;
    logic sub_ok;
    logic [1:0] sub_idx;

    // an element exists only up to the count of present feedbacks
    function automatic logic fb_valid(input logic [7:0] sub, input logic [7:0] cnt);
        fb_valid = (sub != 8'h00) && (sub <= cnt);
    endfunction

    assign hit_revs = obj_req && (obj_index == `OBJ_FEED_REVS);
    assign hit_opt = obj_req && (obj_index == `OBJ_POS_OPT);
    assign sub_ok = fb_valid(obj_subindex, count_q);
    assign sub_idx = obj_subindex[1:0] - 2'h1;

    // ------------------------------------------------
    // feedback count
    // ------------------------------------------------
    // follows the present feedbacks; the sensorless one is always counted
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= `COUNT_RESET;
        end else if (fb_present == 2'h0) begin
            count_q <= 8'h01;
        end else begin
            count_q <= {6'h0, fb_present};
        end
    end

    // ------------------------------------------------
    // shaft revolution array
    // ------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) begin
                revs_q[i] <= `REVS_RESET;
            end
        end else if (hit_revs && obj_write && sub_ok) begin
            revs_q[sub_idx] <= obj_wdata;
        end
    end

    // ------------------------------------------------
    // option word
    // ------------------------------------------------
    // the raw word reads back as written, fields act only on defined codes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            opt_q <= `OPT_RESET;
        end else if (hit_opt && obj_write && obj_subindex == 8'h00) begin
            opt_q <= obj_wdata[15:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rel_q <= rel_ref_t'(`OPT_RESET >> `REL_LSB);
            sro_q <= release_t'(`OPT_RESET >> `SRO_LSB);
            dir_q <= rot_dir_t'(`OPT_RESET >> `DIR_LSB);
        end else if (hit_opt && obj_write && obj_subindex == 8'h00) begin
            if (obj_wdata[`REL_LSB+1 -: 2] != 2'b11) begin
                rel_q <= rel_ref_t'(obj_wdata[`REL_LSB+1 -: 2]);
            end
            if (obj_wdata[`SRO_LSB+1 -: 2] != 2'b11) begin
                sro_q <= release_t'(obj_wdata[`SRO_LSB+1 -: 2]);
            end
            dir_q <= rot_dir_t'(obj_wdata[`DIR_LSB+1 -: 2]);
        end
    end

    // ------------------------------------------------
    // object answer
    // ------------------------------------------------
    // one cycle answer; unknown objects and sub-entries are refused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            obj_ack <= 1'b0;
            obj_err <= 1'b0;
            obj_rdata <= 32'h0;
        end else begin
            obj_ack <= obj_req;
            obj_err <= 1'b0;
            obj_rdata <= 32'h0;
            if (hit_revs && obj_subindex == `SUB_COUNT) begin
                obj_err <= obj_write;
                obj_rdata <= {24'h0, count_q};
            end else if (hit_revs && sub_ok) begin
                obj_rdata <= obj_write ? 32'h0 : revs_q[sub_idx];
            end else if (hit_opt && obj_subindex == 8'h00) begin
                obj_rdata <= {16'h0, opt_q};
            end else if (obj_req) begin
                obj_err <= 1'b1;
            end
        end
    end

    // ------------------------------------------------
    // feed constant
    // ------------------------------------------------
    logic [31:0] divisor;
    logic calc_go;

    // a request for a feedback that is not present is dropped
    assign calc_go = calc_start && fb_valid({6'h0, calc_fb}, count_q);
    assign divisor = revs_q[calc_fb - 2'h1];

    feed_divider u_div (
        .clk(clk),
        .rst_n(rst_n),
        .start(calc_go),
        .dividend(feed_in),
        .divisor(divisor),
        .busy(calc_busy),
        .done_q(calc_done),
        .zero_q(calc_div_zero),
        .quo_q(feed_const)
    );

    // ------------------------------------------------
    // setpoint take-over
    // ------------------------------------------------
    logic nsp_q;
    logic take;
    logic have_q;
    pos_t base;

    // a new setpoint is taken on the rising edge of the command bit
    assign take = cw_new_setpoint && !nsp_q;

    always_comb begin
        case (rel_q)
            REL_PREV: base = have_q ? abs_target : 32'sh0;
            REL_RAMP: base = ramp_pos;
            REL_ACTUAL: base = actual_pos;
            default: base = abs_target;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nsp_q <= 1'b0;
            have_q <= 1'b0;
            abs_target <= 32'sh0;
        end else begin
            nsp_q <= cw_new_setpoint;
            if (take) begin
                have_q <= 1'b1;
                abs_target <= cw_relative ? base + target_in : target_in;
            end
        end
    end

    // ------------------------------------------------
    // self-release
    // ------------------------------------------------
    logic pend_q;

    // the ack clear follows the release by one cycle so the host sees order
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q <= 1'b0;
            cw_release <= 1'b0;
            sw_ack_clear <= 1'b0;
        end else begin
            cw_release <= 1'b0;
            sw_ack_clear <= cw_release;
            if (take) begin
                pend_q <= 1'b1;
            end
            case (sro_q)
                SRO_ON_DONE: begin
                    if (pend_q && move_done && !cw_release) begin
                        cw_release <= 1'b1;
                        pend_q <= take;
                    end
                end
                SRO_EARLY: begin
                    if (take) begin
                        cw_release <= 1'b1;
                        pend_q <= 1'b0;
                    end
                end
                default: pend_q <= pend_q | take;
            endcase
        end
    end

    // ------------------------------------------------
    // rotary direction
    // ------------------------------------------------
    logic pos_c;
    logic via_c;
    logic long_c;

    path_select u_path (
        .mode(dir_q),
        .current(actual_pos),
        .target(abs_target),
        .range_min(range_min),
        .range_max(range_max),
        .move_pos(pos_c),
        .via_limit(via_c),
        .long_ok(long_c)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            move_positive <= 1'b1;
            via_limit <= 1'b0;
            long_move_ok <= 1'b0;
        end else begin
            move_positive <= pos_c;
            via_limit <= via_c;
            long_move_ok <= long_c;
        end
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------
    count_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
        hit_revs && obj_write && obj_subindex == 8'h00 |=> obj_err && obj_ack)
        else $error("count sub-entry accepted a write");
    count_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        hit_revs && !obj_write && obj_subindex == 8'h00
        |=> obj_rdata == {24'h0, $past(count_q)})
        else $error("count read wrong");
    elem_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        hit_revs && obj_subindex == 8'h01 |=> !obj_err)
        else $error("first element refused");
    revs_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        hit_revs && obj_write && obj_subindex == 8'h01
        |=> revs_q[0] == $past(obj_wdata))
        else $error("revolution write lost");
    rel_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
        hit_opt && obj_write && obj_wdata[1:0] == 2'b11 |=> $stable(rel_q))
        else $error("reserved code changed reference");
    rel_prev_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cw_relative && rel_q == REL_PREV
        |=> abs_target == ($past(have_q) ? $past(abs_target) : 32'sh0) + $past(target_in))
        else $error("relative to previous target wrong");
    rel_ramp_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cw_relative && rel_q == REL_RAMP
        |=> abs_target == $past(ramp_pos) + $past(target_in))
        else $error("relative to ramp wrong");
    rel_actual_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && cw_relative && rel_q == REL_ACTUAL
        |=> abs_target == $past(actual_pos) + $past(target_in))
        else $error("relative to actual wrong");
    no_release_a: assert property (@(posedge clk) disable iff (!rst_n)
        sro_q == SRO_NONE && $past(sro_q) == SRO_NONE |-> !cw_release)
        else $error("release while self-release off");
    early_rel_a: assert property (@(posedge clk) disable iff (!rst_n)
        take && sro_q == SRO_EARLY |=> cw_release ##1 sw_ack_clear)
        else $error("early release missing");
    done_rel_a: assert property (@(posedge clk) disable iff (!rst_n)
        sro_q == SRO_ON_DONE && pend_q && move_done && !cw_release |=> cw_release)
        else $error("release on target missing");
    ack_follow_a: assert property (@(posedge clk) disable iff (!rst_n)
        cw_release |=> sw_ack_clear)
        else $error("ack clear did not follow release");
    neg_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(dir_q) == DIR_NEG |-> !move_positive)
        else $error("positive move in negative-only mode");
    pos_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(dir_q) == DIR_POS |-> move_positive && !long_move_ok)
        else $error("negative move in positive-only mode");

    rel_move_c: cover property (@(posedge clk) take && cw_relative);
    early_rel_c: cover property (@(posedge clk) cw_release ##1 sw_ack_clear);
    via_limit_c: cover property (@(posedge clk) via_limit && dir_q == DIR_SHORT);
    div_done_c: cover property (@(posedge clk) calc_done && !calc_div_zero);
endmodule

// >>> sim/obj_host.sv
`timescale 1ns/1ps
// host model at the object port: one access at a time, held to the answer edge
module obj_host (
    // clock
    input wire logic clk,
    // request
    output logic obj_req = 1'b0,
    output logic obj_write = 1'b0,
    output logic [15:0] obj_index = 16'h0000,
    output logic [7:0] obj_subindex = 8'h00,
    output logic [31:0] obj_wdata = 32'h00000000,
    // answer
    input wire logic obj_ack,
    input wire logic obj_err,
    input wire logic [31:0] obj_rdata
);
    // released index and write-data lines show inverted data so a stale value can never look valid
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, output logic err, output logic [31:0] rd);
        @(posedge clk);
        #2;
        obj_req = 1'b1;
        obj_write = w;
        obj_index = idx;
        obj_subindex = sub;
        obj_wdata = wd;
        @(posedge clk);
        #2;
        err = obj_ack ? obj_err : 1'bx; // a missing answer never passes
        rd = obj_rdata;
        obj_req = 1'b0;
        obj_index = ~idx;
        obj_wdata = ~wd;
    endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`include "pos_opt_map.svh"
module tb_top;
    import pos_opt_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic obj_req, obj_write, obj_ack, obj_err, e;
    logic [15:0] obj_index;
    logic [7:0] obj_subindex;
    logic [31:0] obj_wdata, obj_rdata, feed_const, r, d, f;
    logic [31:0] feed_in = 32'h00000000;
    logic calc_start = 1'b0;
    logic [1:0] calc_fb = 2'h1;
    logic [1:0] fb_present = 2'h3;
    logic calc_busy, calc_done, calc_div_zero;
    logic cw_new_setpoint = 1'b0;
    logic cw_relative = 1'b0;
    logic move_done = 1'b0;
    pos_t target_in = 0;
    pos_t ramp_pos = 0;
    pos_t actual_pos = 0;
    pos_t abs_target, t1, t2;
    logic cw_release, sw_ack_clear, move_positive, via_limit, long_move_ok;
    int n_mismatch = 0;
    int cmp_count = 0;
    int seed = 34;
    int cyc = 0;
    int tg[4] = '{2000, 2000, 500, 2000};
    logic ep[4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    logic ev[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    always #12.5 clk = ~clk;

    positioning_option_decoder positioning_option_decoder_i (.clk(clk), .resetn(resetn),
        .obj_req(obj_req), .obj_write(obj_write), .obj_index(obj_index),
        .obj_subindex(obj_subindex), .obj_wdata(obj_wdata), .obj_ack(obj_ack),
        .obj_err(obj_err), .obj_rdata(obj_rdata), .fb_present(fb_present),
        .calc_start(calc_start), .calc_fb(calc_fb), .feed_in(feed_in),
        .calc_busy(calc_busy), .calc_done(calc_done), .calc_div_zero(calc_div_zero),
        .feed_const(feed_const), .cw_new_setpoint(cw_new_setpoint),
        .cw_relative(cw_relative), .move_done(move_done), .target_in(target_in),
        .ramp_pos(ramp_pos), .actual_pos(actual_pos), .range_min(32'sh00000000),
        .range_max(32'sh00000E10), .abs_target(abs_target), .cw_release(cw_release),
        .sw_ack_clear(sw_ack_clear), .move_positive(move_positive), .via_limit(via_limit),
        .long_move_ok(long_move_ok));
    obj_host obj_host_i (.clk(clk), .obj_req(obj_req), .obj_write(obj_write),
        .obj_index(obj_index), .obj_subindex(obj_subindex), .obj_wdata(obj_wdata),
        .obj_ack(obj_ack), .obj_err(obj_err), .obj_rdata(obj_rdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [31:0] quot(input logic [31:0] a, input logic [31:0] b);
        return (b == 32'h00000000) ? 32'h00000000 : a / b;
    endfunction
    task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] v,
        input logic x);
        obj_host_i.xfer(1'b1, i, s, v, e, r);
        chk("obj_err", e, x);
    endtask
    task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
        obj_host_i.xfer(1'b0, i, s, 32'h00000000, e, r);
        chk("obj_err", e, 1'b0);
        chk("obj_rdata", r, x);
    endtask
    task automatic calc(input logic [1:0] fb, input logic [31:0] fv, input logic [31:0] dv);
        int k;
        @(posedge clk);
        #2;
        calc_fb = fb;
        feed_in = fv;
        calc_start = 1'b1;
        @(posedge clk);
        #2;
        calc_start = 1'b0;
        k = 0;
        while (calc_done !== 1'b1 && k < 40) begin
            @(posedge clk);
            #2;
            k++;
        end
        chk("feed_const", feed_const, quot(fv, dv));
        chk("calc_div_zero", calc_div_zero, dv == 32'h00000000);
    endtask
    // edge on the new-setpoint bit; w extra edges let the target settle
    task automatic take(input logic rel, input pos_t t, input int w);
        @(posedge clk);
        #2;
        cw_relative = rel;
        target_in = t;
        cw_new_setpoint = 1'b1;
        @(posedge clk);
        #2;
        cw_new_setpoint = 1'b0;
        repeat (w) @(posedge clk);
        #2;
    endtask
    task automatic wait_rel(input int n, input logic x);
        int k;
        k = 0;
        while (cw_release !== 1'b1 && k < n) begin
            @(posedge clk);
            #2;
            k++;
        end
        chk("cw_release", cw_release, x);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // a hang is cut short long after the sequence should have ended
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            $display("Error timeout expected finish seen hang");
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        #2;
        resetn = 1'b1;
        repeat (4) @(posedge clk);
        rd(`OBJ_FEED_REVS, `SUB_COUNT, 32'h00000003);
        for (int i = 1; i < 4; i++) rd(`OBJ_FEED_REVS, i[7:0], 32'h00000001);
        rd(`OBJ_POS_OPT, 8'h00, 32'h00000001);
        wr(`OBJ_FEED_REVS, `SUB_COUNT, 32'h00000005, 1'b1);
        rd(`OBJ_FEED_REVS, `SUB_COUNT, 32'h00000003);
        wr(`OBJ_FEED_REVS, 8'h04, 32'h00000005, 1'b1);
        wr(16'h1234, 8'h00, 32'h00000005, 1'b1);
        wr(`OBJ_POS_OPT, 8'h01, 32'h00000005, 1'b1);
        rd(`OBJ_POS_OPT, 8'h00, 32'h00000001);
        fb_present = 2'h0;
        rd(`OBJ_FEED_REVS, `SUB_COUNT, 32'h00000001);
        wr(`OBJ_FEED_REVS, 8'h02, 32'h00000005, 1'b1);
        fb_present = 2'h3;
        $display("registers test done");
        for (int i = 1; i < 4; i++) begin
            d = ($random(seed) & 32'h00000FFF) + 32'h00000001;
            f = $random(seed);
            wr(`OBJ_FEED_REVS, i[7:0], d, 1'b0);
            rd(`OBJ_FEED_REVS, i[7:0], d);
            calc(i[1:0], f, d);
        end
        wr(`OBJ_FEED_REVS, 8'h02, 32'h00000000, 1'b0);
        calc(2'h2, f, 32'h00000000);
        $display("feed constant test done");
        t1 = $random(seed) % 1000;
        t2 = $random(seed) % 1000;
        wr(`OBJ_POS_OPT, 8'h00, 32'h00000000, 1'b0);
        take(1'b1, t1, 1);
        chk("abs_target", abs_target, t1);
        take(1'b1, t2, 1);
        chk("abs_target", abs_target, t1 + t2);
        ramp_pos = $random(seed) % 100000;
        wr(`OBJ_POS_OPT, 8'h00, 32'h00000001, 1'b0);
        take(1'b1, t1, 1);
        chk("abs_target", abs_target, ramp_pos + t1);
        actual_pos = $random(seed) % 100000;
        wr(`OBJ_POS_OPT, 8'h00, 32'h00000002, 1'b0);
        take(1'b1, t2, 1);
        chk("abs_target", abs_target, actual_pos + t2);
        wr(`OBJ_POS_OPT, 8'h00, 32'h00000003, 1'b0);
        rd(`OBJ_POS_OPT, 8'h00, 32'h00000003);
        take(1'b1, t1, 1);
        chk("abs_target", abs_target, actual_pos + t1);
        $display("relative reference test done");
        wr(`OBJ_POS_OPT, 8'h00, 32'h00000020, 1'b0);
        take(1'b0, t1, 0);
        wait_rel(2, 1'b1);
        @(posedge clk);
        #2;
        chk("sw_ack_clear", sw_ack_clear, 1'b1);
        wr(`OBJ_POS_OPT, 8'h00, 32'h00000030, 1'b0);
        take(1'b0, t2, 0);
        wait_rel(2, 1'b1);
        wr(`OBJ_POS_OPT, 8'h00, 32'h00000000, 1'b0);
        take(1'b0, t1, 0);
        wait_rel(12, 1'b0);
        wr(`OBJ_POS_OPT, 8'h00, 32'h00000010, 1'b0);
        take(1'b0, t2, 0);
        wait_rel(4, 1'b0);
        move_done = 1'b1;
        wait_rel(3, 1'b1);
        move_done = 1'b0;
        $display("self-release test done");
        actual_pos = 1000;
        for (int m = 0; m < 4; m++) begin
            wr(`OBJ_POS_OPT, 8'h00, m << `DIR_LSB, 1'b0);
            take(1'b0, tg[m], 3);
            chk("move_positive", move_positive, ep[m]);
            chk("via_limit", via_limit, ev[m]);
            chk("long_move_ok", long_move_ok, m == 0);
        end
        take(1'b0, 3000, 3);
        chk("move_positive", move_positive, 1'b0);
        chk("via_limit", via_limit, 1'b1);
        $display("direction test done");
        wrap_up();
    end
endmodule
